// ### dbgx_regs.svh
`ifndef DBGX_REGS_SVH
`define DBGX_REGS_SVH

// ----------------------------------------------------------------------
// Register indices and bus byte offsets
// ----------------------------------------------------------------------
`define DBGX_IDX_STATUS 3'h6
`define DBGX_IDX_CTRL 3'h7
`define DBGX_ADDR_LSB 3
`define DBGX_ADDR_STRIDE 8'h08

// ----------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------
`define DBGX_ST_MATCH_LSB 0
`define DBGX_ST_ACCESS 13
`define DBGX_ST_STEP 14
`define DBGX_ST_TASK 15

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define DBGX_CT_GUARD 13
`define DBGX_CT_TYPE_LSB 16
`define DBGX_CT_LEN_LSB 18
`define DBGX_CT_FIELD_STEP 4

// ----------------------------------------------------------------------
// Access types, lengths and vectors
// ----------------------------------------------------------------------
`define DBGX_TYPE_EXEC 2'h0
`define DBGX_TYPE_WRITE 2'h1
`define DBGX_TYPE_IO 2'h2
`define DBGX_TYPE_RDWR 2'h3
`define DBGX_LEN_1 2'h0
`define DBGX_LEN_2 2'h1
`define DBGX_LEN_8 2'h2
`define DBGX_LEN_4 2'h3
`define DBGX_VEC_DEBUG 8'h01
`define DBGX_VEC_BREAK 8'h03
`define DBGX_GP_CODE 16'h0000

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DBGX_RST_WORD 64'h0000000000000000

`endif

// ### dbgx_pkg.sv
package dbgx_pkg;

  // Operating mode of the core, one-hot.
  typedef enum logic [2:0] {
    DBGX_MODE16 = 3'b001,
    DBGX_MODE32 = 3'b010,
    DBGX_MODE64 = 3'b100
  } dbgx_mode_e;

  // One debug register image.
  typedef logic [63:0] dbgx_word_t;

endpackage : dbgx_pkg

// ### dbgx_core.sv
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "dbgx_regs.svh"
module dbgx_core
  import dbgx_pkg::*;
#(
  parameter int NUM_BP = 4,
  parameter bit LEN8_EN = 1'b1
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave carrying the debug register moves.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_sel_i,
  input wire logic [63:0] wb_dat_i,
  output logic [63:0] wb_dat_o,
  output logic wb_ack_o,
  // Operating mode.
  input wire logic [2:0] mode_i,
  // Instruction boundary.
  input wire logic insn_valid_i,
  input wire logic [63:0] insn_addr_i,
  input wire logic ss_shadow_i,
  // Data and I/O accesses of the running instruction.
  input wire logic acc_valid_i,
  input wire logic [63:0] acc_addr_i,
  input wire logic [3:0] acc_size_i,
  input wire logic acc_write_i,
  input wire logic acc_io_i,
  // Instruction completion.
  input wire logic insn_done_i,
  input wire logic ret_dword_i,
  input wire logic task_switch_i,
  input wire logic saved_resume_i,
  input wire logic step_trap_i,
  input wire logic task_trap_i,
  input wire logic break_insn_i,
  input wire logic other_fault_i,
  // Exception delivery.
  output logic exc_valid_o,
  output logic [7:0] exc_vector_o,
  output logic exc_fault_o,
  output logic exc_trap_o,
  output logic gp_fault_o,
  output logic [15:0] gp_code_o,
  output logic resume_flag_o
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  dbgx_word_t bp_addr [NUM_BP];
  dbgx_word_t spare_reg [2];
  dbgx_word_t status_reg;
  dbgx_word_t ctrl_reg;
  logic resume_flag;
  logic [NUM_BP-1:0] data_hit_q;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Merges the selected byte lanes of a write into the old value.
  function automatic dbgx_word_t lane_merge(input dbgx_word_t old_v,
                                            input dbgx_word_t new_v,
                                            input logic [7:0] sel);
    dbgx_word_t res;
    res = old_v;
    for (int b = 0; b < 8; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Byte mask of the low address bits covered by a length encoding.
  function automatic logic [63:0] len_span(input logic [1:0] len);
    logic [63:0] res;
    res = 64'h0000000000000000;
    unique case (len)
      `DBGX_LEN_1: res = 64'h0000000000000000;
      `DBGX_LEN_2: res = 64'h0000000000000001;
      `DBGX_LEN_4: res = 64'h0000000000000003;
      `DBGX_LEN_8: res = LEN8_EN ? 64'h0000000000000007 : 64'h0;
    endcase
    return res;
  endfunction : len_span

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic [2:0] idx;
  logic mapped;
  logic bus_go;
  logic is_mode64;
  logic guarded;
  logic wr_go;
  logic gp_hit;
  dbgx_word_t wr_val;
  dbgx_word_t rd_val;

  // Each register sits in one aligned 8-byte word.
  assign idx = wb_adr_i[`DBGX_ADDR_LSB +: 3];
  assign mapped = (wb_adr_i[`DBGX_ADDR_LSB-1:0] == 3'h0) &&
                  (wb_adr_i[7:6] == 2'h0);
  assign bus_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign is_mode64 = (mode_i == DBGX_MODE64);
  assign guarded = bus_go && mapped && ctrl_reg[`DBGX_CT_GUARD];
  // In 64-bit mode a write of ones to the reserved top half of status or control is refused.
  assign gp_hit = bus_go && mapped && wb_we_i && !guarded && is_mode64 &&
                  ((idx == `DBGX_IDX_STATUS) || (idx == `DBGX_IDX_CTRL)) &&
                  (|(wb_sel_i[7:4] & {|wb_dat_i[63:56], |wb_dat_i[55:48],
                                      |wb_dat_i[47:40], |wb_dat_i[39:32]}));
  assign wr_go = bus_go && mapped && wb_we_i && !guarded && !gp_hit;

  // Selects the current image of a register.
  always_comb begin
    rd_val = `DBGX_RST_WORD;
    if (idx < 3'(NUM_BP)) begin
      rd_val = bp_addr[idx[1:0]];
    end else if (idx == `DBGX_IDX_STATUS) begin
      rd_val = status_reg;
    end else if (idx == `DBGX_IDX_CTRL) begin
      rd_val = ctrl_reg;
    end else begin
      rd_val = spare_reg[idx[0]];
    end
  end

  // Upper half is zeroed outside 64-bit mode; 64-bit mode keeps all lanes.
  always_comb begin
    wr_val = lane_merge(rd_val, wb_dat_i, wb_sel_i);
    if (!is_mode64) begin
      wr_val[63:32] = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Breakpoint matching
  // ----------------------------------------------------------------------
  logic [NUM_BP-1:0] bp_en;
  logic [NUM_BP-1:0] insn_hit;
  logic [NUM_BP-1:0] acc_hit;
  logic [NUM_BP-1:0] data_hit_all;

  generate
    for (genvar n = 0; n < NUM_BP; n++) begin : g_match
      logic [1:0] kind;
      logic [1:0] len;
      logic [63:0] lo;
      logic [63:0] hi;
      logic [63:0] a_lo;
      logic [63:0] a_hi;
      logic kind_ok;
      assign kind = ctrl_reg[`DBGX_CT_TYPE_LSB + n*`DBGX_CT_FIELD_STEP +: 2];
      assign len = ctrl_reg[`DBGX_CT_LEN_LSB + n*`DBGX_CT_FIELD_STEP +: 2];
      assign bp_en[n] = ctrl_reg[2*n] || ctrl_reg[2*n+1];
      // Instruction hits compare the full address, length ignored.
      assign insn_hit[n] = (kind == `DBGX_TYPE_EXEC) &&
                           (insn_addr_i == bp_addr[n]);
      // The length masks the low bits of the breakpoint address.
      assign lo = bp_addr[n] & ~len_span(len);
      assign hi = lo | len_span(len);
      // I/O addresses are zero extended from 16 bits.
      assign a_lo = acc_io_i ? {48'h0, acc_addr_i[15:0]} : acc_addr_i;
      assign a_hi = a_lo + {60'h0, acc_size_i} - 64'h1;
      always_comb begin
        unique case (kind)
          `DBGX_TYPE_EXEC: kind_ok = 1'b0;
          `DBGX_TYPE_WRITE: kind_ok = acc_write_i && !acc_io_i;
          `DBGX_TYPE_IO: kind_ok = acc_io_i;
          `DBGX_TYPE_RDWR: kind_ok = !acc_io_i;
        endcase
      end
      // Any touched byte inside the range counts.
      assign acc_hit[n] = acc_valid_i && kind_ok && (acc_size_i != 4'h0) &&
                          (a_lo <= hi) && (a_hi >= lo);
    end
  endgenerate

  assign data_hit_all = data_hit_q | acc_hit;

  // ----------------------------------------------------------------------
  // Exception causes
  // ----------------------------------------------------------------------
  logic insn_fire;
  logic trap_fire;
  logic fault_fire;
  logic dbg_fire;
  logic break_fire;

  // Resume flag and stack-load shadow only mute instruction hits.
  assign insn_fire = insn_valid_i && !resume_flag && !ss_shadow_i &&
                     (|(insn_hit & bp_en));
  assign trap_fire = insn_done_i && ((|(data_hit_all & bp_en)) ||
                     step_trap_i || task_trap_i);
  assign fault_fire = insn_fire || guarded;
  assign dbg_fire = fault_fire || trap_fire;
  assign break_fire = insn_done_i && break_insn_i && !dbg_fire;

  // ----------------------------------------------------------------------
  // Accumulated data hits of the running instruction
  // ----------------------------------------------------------------------
  // Hits are held until the instruction completes and then reported.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_hit_q <= '0;
    end else if (ce_i) begin
      if (insn_done_i) begin
        data_hit_q <= '0;
      end else begin
        data_hit_q <= data_hit_all;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Breakpoint address and spare registers
  // ----------------------------------------------------------------------
  // Addresses are stored as written, with no limit check.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_BP; i++) begin
        bp_addr[i] <= `DBGX_RST_WORD;
      end
      spare_reg[0] <= `DBGX_RST_WORD;
      spare_reg[1] <= `DBGX_RST_WORD;
    end else if (ce_i && wr_go) begin
      if (idx < 3'(NUM_BP)) begin
        bp_addr[idx[1:0]] <= wr_val;
      end else if (idx != `DBGX_IDX_STATUS && idx != `DBGX_IDX_CTRL) begin
        spare_reg[idx[0]] <= wr_val;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------------
  // Hardware updates only with an exception and win over a software write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= `DBGX_RST_WORD;
    end else if (ce_i) begin
      if (dbg_fire) begin
        status_reg[`DBGX_ST_MATCH_LSB +: NUM_BP] <=
          (insn_fire ? insn_hit : '0) |
          (trap_fire ? data_hit_all : '0);
        if (guarded) begin
          status_reg[`DBGX_ST_ACCESS] <= 1'b1;
        end
        if (trap_fire && step_trap_i) begin
          status_reg[`DBGX_ST_STEP] <= 1'b1;
        end
        if (trap_fire && task_trap_i) begin
          status_reg[`DBGX_ST_TASK] <= 1'b1;
        end
      end else if (wr_go && idx == `DBGX_IDX_STATUS) begin
        status_reg <= wr_val;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // The guard enable drops on entry to the debug handler.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `DBGX_RST_WORD;
    end else if (ce_i) begin
      if (wr_go && idx == `DBGX_IDX_CTRL) begin
        ctrl_reg <= wr_val;
      end
      if (dbg_fire) begin
        ctrl_reg[`DBGX_CT_GUARD] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Resume flag
  // ----------------------------------------------------------------------
  // Fault entry sets it unless an instruction hit is part of the exception;
  // trap entries come with completion, which clears or reloads it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resume_flag <= 1'b0;
    end else if (ce_i) begin
      if (insn_fire) begin
        resume_flag <= 1'b0;
      end else if (guarded || gp_hit || other_fault_i) begin
        resume_flag <= 1'b1;
      end else if (insn_done_i) begin
        if (ret_dword_i || task_switch_i) begin
          resume_flag <= saved_resume_i;
        end else begin
          resume_flag <= 1'b0;
        end
      end
    end
  end

  assign resume_flag_o = resume_flag;

  // ----------------------------------------------------------------------
  // Exception outputs
  // ----------------------------------------------------------------------
  // One pulse per exception; the debug vector takes precedence over the break vector.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_valid_o <= 1'b0;
      exc_vector_o <= 8'h00;
      exc_fault_o <= 1'b0;
      exc_trap_o <= 1'b0;
    end else if (ce_i) begin
      exc_valid_o <= dbg_fire || break_fire;
      exc_fault_o <= fault_fire;
      exc_trap_o <= trap_fire;
      if (dbg_fire) begin
        exc_vector_o <= `DBGX_VEC_DEBUG;
      end else if (break_fire) begin
        exc_vector_o <= `DBGX_VEC_BREAK;
      end
    end
  end

  // Protection fault pulse for a refused reserved-bit write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gp_fault_o <= 1'b0;
      gp_code_o <= 16'h0000;
    end else if (ce_i) begin
      gp_fault_o <= gp_hit;
      gp_code_o <= `DBGX_GP_CODE;
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  // One wait state, with ack the cycle after the request; guarded or unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 64'h0000000000000000;
    end else if (ce_i) begin
      wb_ack_o <= bus_go;
      if (bus_go && !wb_we_i) begin
        if (!mapped || guarded) begin
          wb_dat_o <= 64'h0000000000000000;
        end else if (is_mode64) begin
          wb_dat_o <= rd_val;
        end else begin
          wb_dat_o <= {32'h00000000, rd_val[31:0]};
        end
      end
    end
  end

endmodule : dbgx_core

// ### dbgx_core_assertions.sv
`timescale 1ns/1ns
`include "dbgx_regs.svh"
// ----------------------------------------------------------------------
// Port-level checks of the debug exception core.
// ----------------------------------------------------------------------
module dbgx_core_chk
  import dbgx_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [63:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [2:0] mode_i,
  // Instruction stream.
  input wire logic insn_valid_i,
  input wire logic ss_shadow_i,
  input wire logic insn_done_i,
  input wire logic ret_dword_i,
  input wire logic task_switch_i,
  input wire logic saved_resume_i,
  input wire logic other_fault_i,
  // Exception outputs.
  input wire logic exc_valid_o,
  input wire logic [7:0] exc_vector_o,
  input wire logic exc_fault_o,
  input wire logic exc_trap_o,
  input wire logic gp_fault_o,
  input wire logic [15:0] gp_code_o,
  input wire logic resume_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answer timing, then the move width rules.
  a_ack_next_cycle: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_gp_code_zero: assert property (
    gp_fault_o |-> gp_code_o == `DBGX_GP_CODE && wb_ack_o &&
    $past(mode_i) == DBGX_MODE64 && $past(wb_we_i))
    else $error("bad gp");
  a_read_low_half: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(mode_i) != DBGX_MODE64 |->
    wb_dat_o[63:32] == 32'h0)
    else $error("upper read");
  // Exception class and vector.
  a_debug_vector: assert property (
    exc_fault_o || exc_trap_o |->
    exc_valid_o && exc_vector_o == `DBGX_VEC_DEBUG)
    else $error("bad vector");
  a_fault_source: assert property (
    exc_fault_o |-> $past(wb_cyc_i && wb_stb_i) ||
    $past(insn_valid_i && !resume_flag_o && !ss_shadow_i))
    else $error("fault");
  a_trap_at_done: assert property (
    exc_trap_o |-> $past(insn_done_i))
    else $error("trap");
  // Resume flag management.
  a_bp_keeps_clear: assert property (
    exc_fault_o && !$past(wb_cyc_i) && !$past(insn_done_i) |->
    !resume_flag_o)
    else $error("resume set");
  a_fault_sets_rf: assert property (
    other_fault_i && !insn_valid_i && !insn_done_i |=> resume_flag_o)
    else $error("resume clear");
  a_done_clears_rf: assert property (
    insn_done_i && !ret_dword_i && !task_switch_i && !other_fault_i |=>
    !resume_flag_o)
    else $error("resume kept");
  a_return_loads_rf: assert property (
    insn_done_i && (ret_dword_i || task_switch_i) && !insn_valid_i &&
    !other_fault_i |=> resume_flag_o == $past(saved_resume_i))
    else $error("resume load");
  // Main scenarios reached.
  c_both_classes: cover property (exc_fault_o && exc_trap_o);
  c_gp_fault: cover property (gp_fault_o);
  c_break_vector: cover property (
    exc_valid_o && exc_vector_o == `DBGX_VEC_BREAK);
endmodule : dbgx_core_chk

bind dbgx_core dbgx_core_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_dat_o, .wb_ack_o, .mode_i, .insn_valid_i, .ss_shadow_i,
  .insn_done_i, .ret_dword_i, .task_switch_i, .saved_resume_i,
  .other_fault_i, .exc_valid_o, .exc_vector_o, .exc_fault_o, .exc_trap_o,
  .gp_fault_o, .gp_code_o, .resume_flag_o);

// ### tb_top.sv
`timescale 1ns/1ns
`include "dbgx_regs.svh"
// ----------------------------------------------------------------------
// Self-checking bench for the debug exception core.
// ----------------------------------------------------------------------
module tb_top
  import dbgx_pkg::*;
;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, h;
  logic insn_valid_i, ss_shadow_i, acc_valid_i, acc_write_i, acc_io_i;
  logic insn_done_i, ret_dword_i, task_switch_i, saved_resume_i, gp;
  logic step_trap_i, task_trap_i, break_insn_i, other_fault_i, exc_valid_o;
  logic exc_fault_o, exc_trap_o, gp_fault_o, resume_flag_o;
  logic [7:0] wb_adr_i, wb_sel_i, exc_vector_o;
  logic [2:0] mode_i;
  logic [3:0] acc_size_i, sz;
  logic [15:0] gp_code_o;
  logic [10:0] e;
  dbgx_word_t wb_dat_i, wb_dat_o, insn_addr_i, acc_addr_i, q, v;
  int err_count, checked, cycles, seed, i;
  // Breakpoint 0 exec, 1 write of 4 bytes, 2 read/write of 8 bytes.
  localparam dbgx_word_t CTRL = 64'h000000000BD00019;
  localparam dbgx_word_t BP0 = 64'hFFFF800000001000;

  // Free-running clock.
  always #5 clk_i = ~clk_i;

  dbgx_core dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mode_i,
    .insn_valid_i, .insn_addr_i, .ss_shadow_i, .acc_valid_i, .acc_addr_i,
    .acc_size_i, .acc_write_i, .acc_io_i, .insn_done_i, .ret_dword_i,
    .task_switch_i, .saved_resume_i, .step_trap_i, .task_trap_i,
    .break_insn_i, .other_fault_i, .exc_valid_o, .exc_vector_o,
    .exc_fault_o, .exc_trap_o, .gp_fault_o, .gp_code_o, .resume_flag_o);

  task report_and_stop;
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task chk(input dbgx_word_t got, input dbgx_word_t exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Vector is only meaningful when an exception is expected.
  task ck_exc(input logic [10:0] x);
    chk(x[10] ? e : {e[10:8], 8'h00}, x);
  endtask : ck_exc

  // One classic Wishbone cycle; the answer is taken at the ack edge.
  task wb(input logic we, input logic [7:0] adr, input dbgx_word_t d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 8'hFF;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    chk(wb_ack_o, 1'b1);
    q = wb_dat_o;
    gp = gp_fault_o;
    e = {exc_valid_o, exc_fault_o, exc_trap_o, exc_vector_o};
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // One boundary, access or completion pulse, then the exception result.
  task pulse(input logic iv, input logic av, input logic dn);
    @(posedge clk_i);
    insn_valid_i <= iv;
    acc_valid_i <= av;
    insn_done_i <= dn;
    @(posedge clk_i);
    {insn_valid_i, acc_valid_i, insn_done_i} <= 3'b000;
    #1;
    e = {exc_valid_o, exc_fault_o, exc_trap_o, exc_vector_o};
  endtask : pulse

  // True when any accessed byte lies inside the breakpoint range.
  function automatic logic hit(dbgx_word_t a, int n, dbgx_word_t b, int len);
    return (a < b + len) && (a + n > b);
  endfunction : hit

  // Hang guard.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  // Main sequence.
  initial begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, insn_valid_i, ss_shadow_i,
      acc_valid_i, acc_write_i, acc_io_i, insn_done_i, ret_dword_i,
      task_switch_i, saved_resume_i, step_trap_i, task_trap_i,
      break_insn_i, other_fault_i} = '0;
    {wb_adr_i, wb_dat_i, insn_addr_i, acc_addr_i, acc_size_i} = '0;
    {rst_i, ce_i, wb_sel_i, mode_i} = {2'b11, 8'hFF, DBGX_MODE64};
    {err_count, checked, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'd33984};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 8; i++) begin
      wb(0, 8'(i * 8), 0);
      chk(q, `DBGX_RST_WORD);
    end
    wb(1, 8'h40, 64'hFF);
    wb(0, 8'h40, 0);
    chk(q, 0);
    for (i = 0; i < 6; i++) begin
      v = {$random(seed), $random(seed)};
      mode_i <= DBGX_MODE64;
      wb(1, 8'(i * 8), v);
      wb(0, 8'(i * 8), 0);
      chk(q, v);
      mode_i <= i[0] ? DBGX_MODE16 : DBGX_MODE32;
      wb(0, 8'(i * 8), 0);
      chk(q, {32'h0, v[31:0]});
      wb(1, 8'(i * 8), ~v);
      mode_i <= DBGX_MODE64;
      wb(0, 8'(i * 8), 0);
      chk(q, {32'h0, ~v[31:0]});
    end
    wb(1, 8'h38, 64'h0000000100000000);
    chk(gp, 1'b1);
    wb(0, 8'h38, 0);
    chk(q, 0);
    wb(1, 8'h00, BP0);
    wb(1, 8'h08, 64'hC0000);
    wb(1, 8'h10, 64'h100);
    wb(1, 8'h38, CTRL);
    pulse(0, 0, 1);
    chk(resume_flag_o, 1'b0);
    insn_addr_i <= BP0;
    pulse(1, 0, 0);
    ck_exc({3'b110, `DBGX_VEC_DEBUG});
    chk(resume_flag_o, 1'b0);
    wb(0, 8'h30, 0);
    chk(q[3:0], 4'h1);
    ss_shadow_i <= 1'b1;
    pulse(1, 0, 0);
    ck_exc(0);
    {ss_shadow_i, saved_resume_i} <= 2'b01;
    pulse(0, 0, 1);
    chk(resume_flag_o, 1'b0);
    ret_dword_i <= 1'b1;
    pulse(0, 0, 1);
    chk(resume_flag_o, 1'b1);
    {ret_dword_i, saved_resume_i} <= 2'b00;
    pulse(1, 0, 0);
    ck_exc(0);
    pulse(0, 0, 1);
    chk(resume_flag_o, 1'b0);
    other_fault_i <= 1'b1;
    pulse(0, 0, 0);
    other_fault_i <= 1'b0;
    chk(resume_flag_o, 1'b1);
    {acc_addr_i, acc_size_i, acc_write_i} <= {64'hC0003, 4'h1, 1'b1};
    pulse(0, 1, 0);
    pulse(0, 0, 1);
    ck_exc({3'b101, `DBGX_VEC_DEBUG});
    chk(resume_flag_o, 1'b0);
    acc_write_i <= 1'b0;
    pulse(0, 1, 0);
    pulse(0, 0, 1);
    ck_exc(0);
    for (i = 0; i < 24; i++) begin
      v = 64'hF8 + ({$random(seed)} % 24);
      sz = 4'(1 + ({$random(seed)} % 4));
      h = hit(v, sz, 64'h100, 8);
      {acc_addr_i, acc_size_i, acc_write_i} <= {v, sz, 1'($random(seed))};
      pulse(0, 1, 0);
      pulse(0, 0, 1);
      ck_exc({h, 1'b0, h, h ? `DBGX_VEC_DEBUG : 8'h00});
    end
    {acc_addr_i, acc_size_i} <= {64'h100, 4'h1};
    pulse(0, 1, 0);
    pulse(1, 0, 1);
    ck_exc({3'b111, `DBGX_VEC_DEBUG});
    wb(0, 8'h30, 0);
    chk(q[3:0], 4'h5);
    break_insn_i <= 1'b1;
    pulse(0, 0, 1);
    break_insn_i <= 1'b0;
    ck_exc({3'b100, `DBGX_VEC_BREAK});
    wb(1, 8'h38, CTRL | 64'h2000);
    wb(0, 8'h08, 0);
    chk(q, 0);
    ck_exc({3'b110, `DBGX_VEC_DEBUG});
    wb(0, 8'h38, 0);
    chk(q, CTRL);
    wb(0, 8'h30, 0);
    chk(q[`DBGX_ST_ACCESS], 1'b1);
    report_and_stop();
  end
endmodule : tb_top
